// *** logic/tvu_trap_unit.sv ***
// trap vectoring unit: trap encoding, priority, entry and error state
//
// Behaviour
// - software writes table base, upper 20 bits
// - non-reset traps write unique 8-bit type
// - low four base bits read zero
// - hardware codes below 0x80, software above
// - 0x60-0x7F implementation traps, rest reserved
// - precise trap while disabled halts into error
// - error entry skips window and counter saves
// - error keeps type, except return-from-trap trap
// - reset trap sets pc 0, npc 4
// - reset initialises enable and supervisor bits
// - reset trap leaves trap type untouched
// - smallest priority number wins, reset first
// - access fault codes at priorities 2 to 5
// - privilege, illegal, disabled codes at 6-8
// - window, alignment, fp/cp codes at 9-11
// - data access, tag, divide codes at 12-15
// - trap instruction at priority 16, 0x80-0xFF
// - interrupt level n uses 0x10+n
// - entry clears enable, saves and sets supervisor
// - entry decrements window pointer modulo count
// - entry saves pc and npc for locals 17/18
// - non-reset entry vectors to base, base+4
`timescale 1ns/1ps
`default_nettype none
`include "tvu_cfg.svh"

module tvu_trap_unit #(
   parameter int WINDOW_COUNT = 8,                 // implemented register windows
   parameter int CWP_W        = 3                  // width of window pointer
) (
   input  wire logic                     clock_i,          // core clock, 200 MHz
   input  wire logic                     rst_n_i,          // async reset, active low
   // register port
   input  wire logic [3:0]               reg_addr_i,       // word address
   input  wire logic [31:0]              reg_wdata_i,      // write data
   input  wire logic                     reg_wr_i,         // write strobe
   input  wire logic                     reg_rd_i,         // read strobe
   output logic      [31:0]              reg_rdata_o,      // read data, one cycle later
   // trap sources from the core, same clock
   input  wire logic [`TVU_NUM_EXC-1:0]  exc_req_i,        // precise exception requests
   input  wire logic                     sw_trap_i,        // trap instruction condition true
   input  wire logic [6:0]               sw_trap_num_i,    // low bits of software trap code
   input  wire logic                     impl_exc_i,       // implementation exception
   input  wire logic [4:0]               impl_num_i,       // its code offset
   input  wire logic                     return_from_trap_instr_i,           // exception raised by return-from-trap
   input  wire logic                     async_exc_i,      // deferred or interrupting exception
   input  wire logic                     boundary_i,       // between instructions
   input  wire logic [31:0]              cur_pc_i,         // program counter of core
   input  wire logic [31:0]              cur_npc_i,        // next program counter of core
   input  wire logic                     psr_wr_i,         // software writes mode bits
   input  wire logic                     psr_et_i,         // value for trap enable bit
   input  wire logic                     psr_s_i,          // value for supervisor bit
   input  wire logic [3:0]               pil_i,            // processor interrupt level
   // pins from outside the clock domain
   input  wire logic                     ext_reset_req_i,  // external reset request
   input  wire logic [3:0]               irl_i,            // interrupt request level
   // state of the block
   output logic                          trap_enable_o,    // trap enable bit
   output logic                          supervisor_o,     // supervisor bit
   output logic                          prev_priv_o,      // previous privilege bit
   output logic      [CWP_W-1:0]         cwp_o,            // current window pointer
   output logic      [31:0]              pc_o,             // program counter
   output logic      [31:0]              npc_o,            // next program counter
   output logic      [31:0]              save_pc_o,        // value for local register 17
   output logic      [31:0]              save_npc_o,       // value for local register 18
   output logic                          save_we_o,        // pulse: write locals of new window
   output logic                          trap_taken_o,     // pulse: trap entry done
   output logic                          error_mode_o      // halted in error state
);
   import tvu_pkg::*;

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic       rst_req_s1_ff, rst_req_ff;   // reset request, two stages
   logic [3:0] irl_s1_ff, irl_ff;           // interrupt level, two stages

   // level pins only: a changing level may be seen one cycle late, and its bits may settle
   // in different cycles, so the second stage can decode a torn level for a cycle
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_req_s1_ff <= 1'b0;
         rst_req_ff    <= 1'b0;
         irl_s1_ff     <= 4'h0;
         irl_ff        <= 4'h0;
      end else begin
         rst_req_s1_ff <= ext_reset_req_i;
         rst_req_ff    <= rst_req_s1_ff;
         irl_s1_ff     <= irl_i;
         irl_ff        <= irl_s1_ff;
      end
   end

   // ----------------------------------------------------------------
   // trap type encoding and priority
   // ----------------------------------------------------------------
   // exception codes, index 0 is highest priority; ties in the table keep index order
   localparam logic [7:0] EXC_TT [`TVU_NUM_EXC] = '{
      `TVU_TT_DSE, `TVU_TT_IMISS,
      `TVU_TT_IAERR, `TVU_TT_RFERR, `TVU_TT_IAEXC,
      `TVU_TT_PRIV, `TVU_TT_ILL,
      `TVU_TT_FPDIS, `TVU_TT_CPDIS, `TVU_TT_FLUSH, `TVU_TT_WATCH,
      `TVU_TT_WOVF, `TVU_TT_WUNF, `TVU_TT_ALIGN,
      `TVU_TT_FPEXC, `TVU_TT_CPEXC,
      `TVU_TT_DAERR, `TVU_TT_DMISS, `TVU_TT_DAEXC,
      `TVU_TT_TAG, `TVU_TT_DIV0
   };

   logic       exc_any;     // any table exception pending
   logic [7:0] exc_tt;      // code of the highest one

   // first set bit wins: smallest priority number
   always_comb begin
      exc_any = 1'b0;
      exc_tt  = 8'h00;
      for (int i = `TVU_NUM_EXC - 1; i >= 0; i--) begin
         if (exc_req_i[i]) begin
            exc_any = 1'b1;
            exc_tt  = EXC_TT[i];
         end
      end
   end

   // interrupt accepted above mask, level 15 unmaskable
   wire       irq_ok  = (irl_ff != 4'h0) &&
                        ((irl_ff == `TVU_IRQ_MAX) || (irl_ff > pil_i));
   wire [7:0] irq_tt  = `TVU_TT_IRQ_BASE | {4'h0, irl_ff};
   wire [7:0] sw_tt   = `TVU_TT_SW_BASE | {1'b0, sw_trap_num_i};
   wire [7:0] impl_tt = `TVU_TT_IMPL_BASE | {3'h0, impl_num_i};

   // precise sources: table exceptions, then trap instruction, then implementation
   wire       precise_any = exc_any | sw_trap_i | impl_exc_i;
   wire [7:0] precise_tt  = exc_any ? exc_tt : (sw_trap_i ? sw_tt : impl_tt);
   wire [7:0] win_tt      = precise_any ? precise_tt : irq_tt;

   // ----------------------------------------------------------------
   // trap state
   // ----------------------------------------------------------------
   tvu_mode_t         mode_ff;          // run or error
   logic [31:12]      tba_ff;           // table base field
   logic [7:0]        tt_ff;            // trap type code
   logic              et_ff;            // trap enable bit
   logic              s_ff;             // supervisor bit
   logic              ps_ff;            // previous privilege bit
   logic [CWP_W-1:0]  cwp_ff;           // current window pointer
   logic [31:0]       pc_ff;            // program counter
   logic [31:0]       npc_ff;           // next program counter
   logic [31:0]       spc_ff;           // counter saved for local 17
   logic [31:0]       snpc_ff;          // counter saved for local 18
   logic              save_we_ff;       // write pulse for the locals
   logic              taken_ff;         // trap or reset entry pulse
   logic [31:0]       rdata_ff;         // read data register

   wire [31:0] vbase = {tba_ff, tt_ff, {`TVU_LOW_W{1'b0}}};
   wire        run   = (mode_ff == TVU_RUN);

   // event decode; reset outranks every other source, so the three never coincide
   wire do_reset   = rst_req_ff;
   // a deferred or interrupting exception has no code of its own: it rides on the table
   // source that names it; with the enable bit low that source is dropped, not halted on
   wire do_trap    = run && !do_reset && boundary_i && et_ff &&
                     (precise_any || irq_ok);
   wire do_error   = run && !do_reset && boundary_i && !et_ff && precise_any &&
                     !async_exc_i;
   // wrap by hand: a window count below a power of two must not reach unused codes
   wire [CWP_W-1:0] nxt_cwp = (cwp_ff == '0) ? CWP_W'(WINDOW_COUNT - 1)
                                             : cwp_ff - 1'b1;
   wire [31:0] nxt_vbase = {tba_ff, win_tt, {`TVU_LOW_W{1'b0}}};

   // mode machine; only reset leaves the error state
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mode_ff <= TVU_RUN;
      end else if (do_reset) begin
         mode_ff <= TVU_RUN;
      end else if (do_error) begin
         mode_ff <= TVU_ERROR;
      end
   end

   // mode bits of the processor state word
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         et_ff <= 1'b0;
         s_ff  <= 1'b1;
         ps_ff <= 1'b0;
      end else if (do_reset) begin
         et_ff <= 1'b0;
         s_ff  <= 1'b1;
      end else if (do_trap) begin
         et_ff <= 1'b0;
         ps_ff <= s_ff;
         s_ff  <= 1'b1;
      end else if (psr_wr_i && run) begin
         et_ff <= psr_et_i;
         s_ff  <= psr_s_i;
      end
   end

   // trap type: normal traps and the single error case write it, reset never does
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tt_ff <= 8'h00;               // undefined after power-up, zero here
      end else if (do_reset) begin
         tt_ff <= tt_ff;
      end else if (do_trap) begin
         tt_ff <= win_tt;
      end else if (do_error && return_from_trap_instr_i) begin
         tt_ff <= precise_tt;
      end
   end

   // table base: software write only; the type field beside it is written by hardware traps alone
   // low twelve bits of a write are dropped: type and zero field belong to hardware
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tba_ff <= '0;
      end else if (reg_wr_i && reg_addr_i == `TVU_ADDR_VBASE) begin
         tba_ff <= reg_wdata_i[31:`TVU_TBA_LSB];
      end
   end

   // window pointer and saved counters; skipped on error entry
   // the core writes the locals of the new window one cycle after entry, on the pulse
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cwp_ff     <= '0;
         spc_ff     <= 32'h0;
         snpc_ff    <= 32'h0;
         save_we_ff <= 1'b0;
      end else begin
         save_we_ff <= do_trap;
         if (do_trap) begin
            cwp_ff  <= nxt_cwp;
            spc_ff  <= cur_pc_i;
            snpc_ff <= cur_npc_i;
         end
      end
   end

   // program counters
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pc_ff    <= `TVU_RESET_PC;
         npc_ff   <= `TVU_RESET_NPC;
         taken_ff <= 1'b0;
      end else begin
         taken_ff <= do_trap | do_reset;
         if (do_reset) begin
            pc_ff  <= `TVU_RESET_PC;
            npc_ff <= `TVU_RESET_NPC;
         end else if (do_trap) begin
            pc_ff  <= nxt_vbase;
            npc_ff <= nxt_vbase + `TVU_PC_STEP;
         end
      end
   end

   // ----------------------------------------------------------------
   // register read port
   // ----------------------------------------------------------------
   // state word: enable, supervisor, previous, mode, then window pointer from bit 4
   wire [31:0] state_word = {{(32-CWP_W-4){1'b0}}, cwp_ff, mode_ff, ps_ff, s_ff, et_ff};
   // unmapped addresses read zero
   wire [31:0] rd_mux =
      (reg_addr_i == `TVU_ADDR_VBASE)   ? vbase   :
      (reg_addr_i == `TVU_ADDR_STATE)   ? state_word :
      (reg_addr_i == `TVU_ADDR_PC)      ? pc_ff   :
      (reg_addr_i == `TVU_ADDR_NPC)     ? npc_ff  :
      (reg_addr_i == `TVU_ADDR_SAVEPC)  ? spc_ff  :
      (reg_addr_i == `TVU_ADDR_SAVENPC) ? snpc_ff : 32'h0;

   // data stand only in the cycle after the strobe
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_ff <= 32'h0;
      end else begin
         rdata_ff <= reg_rd_i ? rd_mux : 32'h0;
      end
   end

   // every output is a register bit; no logic after the flops
   assign reg_rdata_o   = rdata_ff;
   assign trap_enable_o = et_ff;
   assign supervisor_o  = s_ff;
   assign prev_priv_o   = ps_ff;
   assign cwp_o         = cwp_ff;
   assign pc_o          = pc_ff;
   assign npc_o         = npc_ff;
   assign save_pc_o     = spc_ff;
   assign save_npc_o    = snpc_ff;
   assign save_we_o     = save_we_ff;
   assign trap_taken_o  = taken_ff;
   assign error_mode_o  = mode_ff;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);

   // register view and vectoring
   a_low_bits_zero: assert property (reg_rd_i && reg_addr_i == `TVU_ADDR_VBASE |=>
                                     reg_rdata_o[3:0] == 4'h0)
      else $error("vector base low bits not zero");
   a_trap_vector: assert property (do_trap |=>
                                   pc_ff == vbase && npc_ff == vbase + 32'h4)
      else $error("trap vector wrong");

   // reset trap
   a_reset_vector: assert property (do_reset |=> pc_ff == 32'h0 && npc_ff == 32'h4)
      else $error("reset vector wrong");
   a_reset_keeps_tt: assert property (do_reset |=> $stable(tt_ff))
      else $error("reset wrote trap type");

   // entry actions and error state
   a_entry_mode: assert property (do_trap |=> !et_ff && s_ff && ps_ff == $past(s_ff))
      else $error("entry mode bits wrong");
   a_error_halts: assert property (do_error |=>
                                   error_mode_o && $stable(cwp_ff) && !save_we_ff)
      else $error("error entry altered state");
   a_error_tt: assert property (do_error && !return_from_trap_instr_i |=> $stable(tt_ff))
      else $error("error entry wrote trap type");
   a_cwp_decr: assert property (do_trap |=> cwp_ff == ((($past(cwp_ff) + WINDOW_COUNT - 1))
                                   % WINDOW_COUNT))
      else $error("window pointer not decremented");

   // codes and priority
   a_irq_code: assert property (do_trap && !precise_any && irq_ok |=>
                                tt_ff == {4'h1, $past(irl_ff)})
      else $error("interrupt code wrong");
   a_priority_top: assert property (do_trap && exc_req_i[0] |=> tt_ff == 8'h2b)
      else $error("top priority not taken");
   a_sw_range: assert property (do_trap && !exc_any && sw_trap_i |=> tt_ff[7])
      else $error("software trap code out of range");


   // main scenarios seen at least once
   c_normal_trap: cover property (do_trap ##1 trap_taken_o);
   c_error_entry: cover property (do_error ##[1:20] do_reset);
   c_irq_trap:    cover property (do_trap && !precise_any);
   c_return_from_trap_instr_error:  cover property (do_error && return_from_trap_instr_i);
   c_reset_trap:  cover property ($rose(do_reset));
endmodule : tvu_trap_unit
`default_nettype wire

// *** logic/tvu_cfg.svh ***
// constants for the trap vectoring unit: offsets, fields, codes, vectors
`ifndef TVU_CFG_SVH
`define TVU_CFG_SVH
// register map (word addresses on the plain register port)
`define TVU_ADDR_VBASE   4'h0
`define TVU_ADDR_STATE   4'h1
`define TVU_ADDR_PC      4'h2
`define TVU_ADDR_NPC     4'h3
`define TVU_ADDR_SAVEPC  4'h4
`define TVU_ADDR_SAVENPC 4'h5
// field layout of the vector base register
`define TVU_TBA_LSB      12
`define TVU_TT_LSB       4
`define TVU_TT_W         8
`define TVU_LOW_W        4
// reset vector and counter step
`define TVU_RESET_PC     32'h0000_0000
`define TVU_RESET_NPC    32'h0000_0004
`define TVU_PC_STEP      32'h0000_0004
// trap type codes
`define TVU_TT_DSE       8'h2b
`define TVU_TT_IMISS     8'h3c
`define TVU_TT_IAERR     8'h21
`define TVU_TT_RFERR     8'h20
`define TVU_TT_IAEXC     8'h01
`define TVU_TT_PRIV      8'h03
`define TVU_TT_ILL       8'h02
`define TVU_TT_FPDIS     8'h04
`define TVU_TT_CPDIS     8'h24
`define TVU_TT_FLUSH     8'h25
`define TVU_TT_WATCH     8'h0b
`define TVU_TT_WOVF      8'h05
`define TVU_TT_WUNF      8'h06
`define TVU_TT_ALIGN     8'h07
`define TVU_TT_FPEXC     8'h08
`define TVU_TT_CPEXC     8'h28
`define TVU_TT_DAERR     8'h29
`define TVU_TT_DMISS     8'h2c
`define TVU_TT_DAEXC     8'h09
`define TVU_TT_TAG       8'h0a
`define TVU_TT_DIV0      8'h2a
`define TVU_TT_SW_BASE   8'h80
`define TVU_TT_IRQ_BASE  8'h10
`define TVU_TT_IMPL_BASE 8'h60
`define TVU_IRQ_MAX      4'hf
`define TVU_NUM_EXC      21
`endif

// *** logic/tvu_pkg.sv ***
// types shared by the trap vectoring unit
package tvu_pkg;
   typedef enum logic [0:0] {
      TVU_RUN   = 1'b0,   // executing, traps may be taken
      TVU_ERROR = 1'b1    // halted, waits for external reset
   } tvu_mode_t;
endpackage : tvu_pkg

// *** tb/tvu_src_model.sv ***
// partner model: external reset request and interrupt request level pins
`timescale 1ns/1ps
`default_nettype none

module tvu_src_model (
   input  wire logic       clock_i,          // core clock
   input  wire logic       rst_req_i,        // bench asks for a reset request
   input  wire logic [3:0] lvl_i,            // bench asks for this request level
   output logic            ext_reset_req_o,  // reset request pin
   output logic      [3:0] irl_o             // interrupt request level pin
);
   // ----------------------------------------
   // pin drivers
   // ----------------------------------------
   // pins move one edge after the request, like a source on another board;
   // the bench holds the block in reset for four edges, until the pins have settled
   always @(posedge clock_i) begin
      ext_reset_req_o <= rst_req_i;
      irl_o           <= lvl_i;
   end
endmodule : tvu_src_model

`default_nettype wire

// *** tb/tvu_trap_unit_tb_top.sv ***
// self-checking testbench of the trap vectoring unit
`timescale 1ns/1ps
`default_nettype none

module tvu_trap_unit_tb_top;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic        clock_i, rst_n_i, reg_wr_i, reg_rd_i;      // clock, reset, strobes
   logic [3:0]  reg_addr_i, pil_i, irl_i, lvl;             // address, levels
   logic [31:0] reg_wdata_i, reg_rdata_o, cur_pc_i, cur_npc_i;
   logic [20:0] exc_req_i;                                 // precise requests
   logic [6:0]  sw_trap_num_i;                             // software code bits
   logic [4:0]  impl_num_i;                                // implementation offset
   logic        sw_trap_i, impl_exc_i, return_from_trap_instr_i, async_exc_i, boundary_i;
   logic        psr_wr_i, psr_et_i, psr_s_i, ext_reset_req_i, rst_req;
   logic        trap_enable_o, supervisor_o, prev_priv_o, save_we_o, trap_taken_o, error_mode_o;
   logic [2:0]  cwp_o, exp_cwp;                            // window pointer, expected
   logic [31:0] pc_o, npc_o, save_pc_o, save_npc_o, exp_pc;
   logic        exp_s;                                     // supervisor before entry
   logic [7:0]  tt_tab [21];                               // codes in priority order
   int          err_count, checks, i;

   tvu_trap_unit #(.WINDOW_COUNT(8), .CWP_W(3)) tvu_trap_unit_inst (
      .clock_i(clock_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_rdata_o(reg_rdata_o), .exc_req_i(exc_req_i), .sw_trap_i(sw_trap_i),
      .sw_trap_num_i(sw_trap_num_i), .impl_exc_i(impl_exc_i), .impl_num_i(impl_num_i),
      .return_from_trap_instr_i(return_from_trap_instr_i), .async_exc_i(async_exc_i), .boundary_i(boundary_i),
      .cur_pc_i(cur_pc_i), .cur_npc_i(cur_npc_i), .psr_wr_i(psr_wr_i),
      .psr_et_i(psr_et_i), .psr_s_i(psr_s_i), .pil_i(pil_i),
      .ext_reset_req_i(ext_reset_req_i), .irl_i(irl_i), .trap_enable_o(trap_enable_o),
      .supervisor_o(supervisor_o), .prev_priv_o(prev_priv_o), .cwp_o(cwp_o),
      .pc_o(pc_o), .npc_o(npc_o), .save_pc_o(save_pc_o), .save_npc_o(save_npc_o),
      .save_we_o(save_we_o), .trap_taken_o(trap_taken_o), .error_mode_o(error_mode_o));

   tvu_src_model tvu_src_model_inst (
      .clock_i(clock_i), .rst_req_i(rst_req), .lvl_i(lvl),
      .ext_reset_req_o(ext_reset_req_i), .irl_o(irl_i));

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // compare and count; four-state compare so an unknown never matches
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
         err_count++;
      end
   endtask : chk

   // one-cycle write strobe
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clock_i);
      reg_wr_i    <= 1'b1;
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      @(posedge clock_i);
      reg_wr_i    <= 1'b0;
   endtask : wr

   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string name);
      @(posedge clock_i);
      reg_rd_i   <= 1'b1;
      reg_addr_i <= a;
      @(posedge clock_i);
      reg_rd_i   <= 1'b0;
      #1 chk(name, exp, reg_rdata_o);
   endtask : rd

   // software sets trap enable and the supervisor bit; ends on an edge
   task automatic en(input logic s);
      @(posedge clock_i);
      psr_wr_i <= 1'b1;
      psr_et_i <= 1'b1;
      psr_s_i  <= s;
      @(posedge clock_i);
      psr_wr_i <= 1'b0;
      exp_s = s;
   endtask : en

   // one boundary cycle, then check entry state or that nothing moved
   task automatic fire(input logic [7:0] tt, input logic take);
      logic [31:0] vec;
      vec = {20'habcde, tt, 4'h0};
      @(posedge clock_i);
      boundary_i <= 1'b1;
      @(posedge clock_i);
      boundary_i  <= 1'b0;
      exc_req_i   <= '0;
      sw_trap_i   <= 1'b0;
      impl_exc_i  <= 1'b0;
      async_exc_i <= 1'b0;
      lvl         <= 4'h0;
      #1 chk("taken", {31'h0, take}, {31'h0, trap_taken_o});
      if (take) begin
         exp_cwp = exp_cwp - 3'h1;
         exp_pc  = vec;
         chk("pc", vec, pc_o);
         chk("npc", vec + 32'h4, npc_o);
         chk("mode", {29'h0, 2'b01, exp_s},
             {29'h0, trap_enable_o, supervisor_o, prev_priv_o});
         chk("cwp", {29'h0, exp_cwp}, {29'h0, cwp_o});
         chk("save pc", cur_pc_i, save_pc_o);
         chk("save npc", cur_npc_i, save_npc_o);
         chk("save we", 32'h1, {31'h0, save_we_o});
      end else begin
         chk("pc hold", exp_pc, pc_o);
      end
   endtask : fire

   // error entry: halt, nothing saved, counters kept, type checked
   task automatic errent(input logic [7:0] tt);
      @(posedge clock_i);
      boundary_i <= 1'b1;
      @(posedge clock_i);
      boundary_i <= 1'b0;
      exc_req_i  <= '0;
      return_from_trap_instr_i     <= 1'b0;
      #1 chk("error", 32'h1, {31'h0, error_mode_o});
      chk("err pc", exp_pc, pc_o);
      chk("err we", 32'h0, {31'h0, save_we_o});
      rd(4'h0, {20'habcde, tt, 4'h0}, "err type");
   endtask : errent

   // reset trap through the partner pin; also the way out of error
   task automatic rtrap();
      @(posedge clock_i);
      rst_req <= 1'b1;
      repeat (6) @(posedge clock_i);
      #1 chk("rst pc", 32'h0, pc_o);
      chk("rst npc", 32'h4, npc_o);
      chk("rst et s", 32'h1, {30'h0, trap_enable_o, supervisor_o});
      chk("rst err", 32'h0, {31'h0, error_mode_o});
      @(posedge clock_i);
      rst_req <= 1'b0;
      repeat (4) @(posedge clock_i);
      exp_pc = 32'h0;
   endtask : rtrap

   // verdict, the single end of the run
   task automatic summarize();
      if (err_count == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : summarize

   // ----------------------------------------
   // clock, watchdog, sequence
   // ----------------------------------------
   initial begin
      clock_i = 1'b0;
      forever #2.5 clock_i = ~clock_i;
   end

   // a run this short never needs more than a few thousand edges
   initial begin
      repeat (5000) @(posedge clock_i);
      err_count++;
      summarize();
   end

   initial begin
      {rst_n_i, reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i, exc_req_i} = '0;
      {sw_trap_i, sw_trap_num_i, impl_exc_i, impl_num_i, return_from_trap_instr_i, async_exc_i} = '0;
      {boundary_i, cur_pc_i, cur_npc_i, psr_wr_i, psr_et_i, psr_s_i, pil_i} = '0;
      {rst_req, lvl, err_count, checks} = '0;
      tt_tab = '{8'h2b, 8'h3c, 8'h21, 8'h20, 8'h01, 8'h03, 8'h02, 8'h04, 8'h24, 8'h25,
                 8'h0b, 8'h05, 8'h06, 8'h07, 8'h08, 8'h28, 8'h29, 8'h2c, 8'h09, 8'h0a, 8'h2a};
      exp_cwp = 3'h0;
      exp_pc  = 32'h0;
      repeat (4) @(posedge clock_i);
      rst_n_i <= 1'b1;
      rd(4'h2, 32'h0, "pc");
      rd(4'h3, 32'h4, "npc");
      wr(4'h0, 32'habcd_efff);
      rd(4'h0, 32'habcd_e000, "base");
      wr(4'h2, 32'h5555_5555);
      rd(4'h2, 32'h0, "pc write");
      rd(4'hf, 32'h0, "unmapped");
      // each request with every lower one pending beside it
      for (i = 0; i < 21; i++) begin
         en(i[0]);
         exc_req_i <= 21'h1f_ffff << i;
         sw_trap_i <= 1'b1;
         lvl       <= 4'hf;
         cur_pc_i  <= 32'h100 + 32'(i * 8);
         cur_npc_i <= 32'h104 + 32'(i * 8);
         fire(tt_tab[i], 1'b1);
      end
      // trap instruction beats the implementation exception
      en(1'b1);
      sw_trap_i     <= 1'b1;
      sw_trap_num_i <= 7'h7f;
      impl_exc_i    <= 1'b1;
      impl_num_i    <= 5'h1f;
      fire(8'hff, 1'b1);
      en(1'b0);
      impl_exc_i <= 1'b1;
      fire(8'h7f, 1'b1);
      // every interrupt level, through the pin synchronisers
      for (i = 1; i < 16; i++) begin
         en(i[0]);
         lvl <= i[3:0];
         repeat (3) @(posedge clock_i);
         fire(8'h10 + 8'(i), 1'b1);
      end
      // traps disabled: interrupts and deferred exceptions are dropped
      @(posedge clock_i);
      lvl         <= 4'hf;
      async_exc_i <= 1'b1;
      exc_req_i   <= 21'h1 << 14;
      repeat (3) @(posedge clock_i);
      fire(8'h00, 1'b0);
      chk("no err", 32'h0, {31'h0, error_mode_o});
      @(posedge clock_i);
      exc_req_i <= 21'h1 << 13;
      errent(8'h1f);
      rtrap();
      rd(4'h0, 32'habcd_e1f0, "rst type");
      // return-from-trap fault while disabled records its type
      @(posedge clock_i);
      exc_req_i <= 21'h1 << 12;
      return_from_trap_instr_i    <= 1'b1;
      errent(8'h06);
      rtrap();
      summarize();
   end
endmodule : tvu_trap_unit_tb_top

`default_nettype wire
